// ===== verilog/sso_read.sv
/*
 * Serial read engine for security registers and the unique identifier,
 * plus its byte FIFO.
 * Assumes the serial clock is at most an eighth of clk, that the array
 * answers fetches with valid/ready, and that busy comes from clk logic.
 */
//
// Overview of operation
// - Security read: chip select low, code 48h, 24-bit address, eight dummy clocks.
// - Code and address bits sampled on serial clock rising edges.
// - After dummy clocks, bytes leave MSB first, changing on falling edges.
// - Nonzero upper address byte gives undefined data.
// - Byte address advances by one after each byte.
// - Offset FFh wraps to 00h of the same register.
// - Chip select high stops driving and ends the command.
// - Security read while busy is ignored without disturbing the cycle.
// - Addresses outside the three registers give undefined results.
// - Identifier read: code 4Bh, zero address, one dummy byte.
// - After the dummy byte the fixed 128-bit identifier shifts out.
`timescale 1ns/1ps

module sso_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock, reset and flush.
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    // Fill side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (flush) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= push ? AW'((wr_q + 1'b1) % DEPTH) : wr_q;
            rd_q <= pop ? AW'((rd_q + 1'b1) % DEPTH) : rd_q;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : sso_fifo

module sso_read
    import sso_pkg::*;
#(
    parameter logic [127:0] UID = SSO_UID_DEFAULT
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Serial pins from the host.
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic serial_in_pin,
    // Serial data output, enable low while driving.
    output logic serial_out,
    output logic serial_out_oe_n,
    // Device status.
    input wire logic busy,
    // Security register array fetch port.
    output sso_addr_s fetch_addr,
    output logic fetch_ready,
    input wire logic fetch_valid,
    input wire logic [7:0] fetch_data
);
    sso_pins_s s1_q;
    sso_pins_s s2_q;
    logic sclk_prev_q;
    sso_state_e state_q;
    logic [4:0] cnt_q;
    logic [7:0] op_q;
    logic uid_mode_q;
    logic [22:0] addr_sh_q;
    sso_addr_s addr_q;
    logic fetch_on_q;
    logic [3:0] uid_idx_q;
    logic [2:0] out_cnt_q;
    logic [7:0] out_sh_q;
    logic drive_q;

    wire rise = s2_q.sclk & ~sclk_prev_q;
    wire fall = ~s2_q.sclk & sclk_prev_q;
    wire sel = ~s2_q.cs_n;
    wire [7:0] op_full = {op_q[6:0], s2_q.sin};
    wire op_sec = (op_full == SSO_OP_SECREG_RD);
    wire op_uid = (op_full == SSO_OP_UID_RD);
    wire [7:0] uid_byte = UID[{~uid_idx_q, 3'h0} +: 8];
    wire src_valid = uid_mode_q ? 1'b1 : fetch_valid;
    wire [7:0] src_data = uid_mode_q ? uid_byte : fetch_data;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire load = fall & (state_q == SSO_ST_DATA) & (out_cnt_q == 3'h0);
    wire push = fetch_on_q & src_valid & fifo_in_ready;

    assign fetch_addr = addr_q;
    assign fetch_ready = fetch_on_q & ~uid_mode_q & fifo_in_ready;
    assign serial_out = out_sh_q[7];
    assign serial_out_oe_n = ~drive_q;

    sso_fifo #(
        .WIDTH(SSO_FIFO_WIDTH),
        .DEPTH(SSO_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .flush(~sel),
        .in_valid(fetch_on_q & src_valid),
        .in_ready(fifo_in_ready),
        .in_data(src_data),
        .out_valid(fifo_out_valid),
        .out_ready(load),
        .out_data(fifo_out_data)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= SSO_PINS_IDLE;
            s2_q <= SSO_PINS_IDLE;
            sclk_prev_q <= 1'b0;
        end else begin
            s1_q <= '{cs_n: cs_n_pin, sclk: sclk_pin, sin: serial_in_pin};
            s2_q <= s1_q;
            sclk_prev_q <= s2_q.sclk;
        end
    end

    // Command, address and dummy phases on rising edges.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= SSO_ST_CMD;
            cnt_q <= '0;
            op_q <= '0;
            uid_mode_q <= 1'b0;
            addr_sh_q <= '0;
        end else if (!sel) begin
            state_q <= SSO_ST_CMD;
            cnt_q <= '0;
            op_q <= '0;
        end else if (rise) begin
            cnt_q <= cnt_q + 5'h01;
            case (state_q)
                SSO_ST_CMD: begin
                    op_q <= op_full;
                    if (cnt_q == SSO_CMD_BITS) begin
                        cnt_q <= '0;
                        uid_mode_q <= op_uid;
                        // Busy device ignores a security read; an identifier read still proceeds.
                        state_q <= ((op_sec & ~busy) | op_uid) ?
                            SSO_ST_ADDR : SSO_ST_IGNORE;
                    end
                end
                SSO_ST_ADDR: begin
                    addr_sh_q <= {addr_sh_q[21:0], s2_q.sin};
                    if (cnt_q == SSO_ADDR_BITS) begin
                        cnt_q <= '0;
                        state_q <= SSO_ST_DUMMY;
                    end
                end
                SSO_ST_DUMMY: begin
                    if (cnt_q == SSO_DUMMY_BITS) begin
                        state_q <= SSO_ST_DATA;
                    end
                end
                default: begin
                    cnt_q <= cnt_q;
                end
            endcase
        end
    end

    // Prefetch into the FIFO from the address onward.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_q <= '0;
            fetch_on_q <= 1'b0;
            uid_idx_q <= '0;
        end else if (!sel) begin
            fetch_on_q <= 1'b0;
            uid_idx_q <= '0;
        end else if (rise && state_q == SSO_ST_ADDR &&
                     cnt_q == SSO_ADDR_BITS) begin
            // Upper and select bytes pass unchecked.
            addr_q <= {addr_sh_q, s2_q.sin};
            fetch_on_q <= 1'b1;
            uid_idx_q <= '0;
        end else if (push) begin
            // Offset wraps within the selected register.
            addr_q.offset <= addr_q.offset + 8'h01;
            uid_idx_q <= uid_idx_q + 4'h1;
        end
    end

    // Output shifter on falling edges.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_cnt_q <= '0;
            out_sh_q <= '0;
            drive_q <= 1'b0;
        end else if (!sel) begin
            out_cnt_q <= '0;
            drive_q <= 1'b0;
        end else if (fall && state_q == SSO_ST_DATA) begin
            out_cnt_q <= out_cnt_q + 3'h1;
            drive_q <= 1'b1;
            out_sh_q <= load ? fifo_out_data
                             : {out_sh_q[6:0], 1'b0};
        end
    end
endmodule : sso_read

// ===== verilog/sso_pkg.sv
/*
 * Shared types and constants for the security register and unique
 * identifier read logic of the serial flash.
 * Assumes a single system clock; the serial pins are asynchronous to it.
 */
package sso_pkg;

    // Command codes.
    localparam logic [7:0] SSO_OP_SECREG_RD = 8'h48;
    localparam logic [7:0] SSO_OP_UID_RD = 8'h4B;

    // Phase lengths in serial clock edges, less one.
    localparam logic [4:0] SSO_CMD_BITS = 5'h07;
    localparam logic [4:0] SSO_ADDR_BITS = 5'h17;
    localparam logic [4:0] SSO_DUMMY_BITS = 5'h07;

    // Data path geometry.
    localparam int SSO_FIFO_WIDTH = 8;
    localparam int SSO_FIFO_DEPTH = 8;
    localparam logic [3:0] SSO_UID_LAST = 4'hF;

    // Identifier value is arbitrary.
    localparam logic [127:0] SSO_UID_DEFAULT =
        128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;

    typedef enum logic [2:0] {
        SSO_ST_CMD,
        SSO_ST_ADDR,
        SSO_ST_DUMMY,
        SSO_ST_DATA,
        SSO_ST_IGNORE
    } sso_state_e;

    // Serial pin levels after synchronisation.
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic sin;
    } sso_pins_s;

    // Security register address split into its bytes.
    typedef struct packed {
        logic [7:0] upper;
        logic [7:0] select;
        logic [7:0] offset;
    } sso_addr_s;

    localparam sso_pins_s SSO_PINS_IDLE = '{cs_n: 1'b1, sclk: 1'b0,
                                            sin: 1'b0};

endpackage : sso_pkg

// ===== testbench/sso_chk_sva.sv
/* Pin and fetch port assertions for the read engine.
   Assumes it is bound to the engine's top module. */
`timescale 1ns/1ps
module sso_chk_sva
    import sso_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Serial pins.
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic serial_out,
    input wire logic serial_out_oe_n,
    // Fetch port.
    input wire sso_addr_s fetch_addr,
    input wire logic fetch_ready,
    input wire logic fetch_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic take;
    assign take = fetch_valid && fetch_ready && !cs_n_pin;
    a_oe_idle_off: assert property (cs_n_pin [*5] |-> serial_out_oe_n)
        else $error("output enabled while deselected");
    a_oe_end_fast: assert property ($rose(cs_n_pin) |-> ##[1:5] serial_out_oe_n)
        else $error("output not released after deselect");
    a_fetch_idle: assert property (cs_n_pin [*6] |-> !fetch_ready)
        else $error("fetch while deselected");
    a_offset_step: assert property (take ##1 !cs_n_pin |->
        fetch_addr.offset == 8'($past(fetch_addr.offset) + 8'h01))
        else $error("offset did not step by one");
    a_select_kept: assert property (take ##1 !cs_n_pin |->
        $stable(fetch_addr.select))
        else $error("register select changed on wrap");
    a_out_sclk_low: assert property (!serial_out_oe_n && $changed(serial_out)
        |-> !sclk_pin)
        else $error("data changed while serial clock high");
    a_oe_start_low: assert property ($fell(serial_out_oe_n) |->
        !sclk_pin && !cs_n_pin)
        else $error("output enabled off a falling edge");
    a_oe_held_on: assert property (!serial_out_oe_n && !cs_n_pin |=>
        !serial_out_oe_n)
        else $error("output dropped inside the frame");
endmodule : sso_chk_sva
bind sso_read sso_chk_sva u_chk (.clk(clk), .rst(rst), .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .fetch_addr(fetch_addr),
    .fetch_ready(fetch_ready), .fetch_valid(fetch_valid));

// ===== testbench/sso_host.sv
/* SPI host model that frames reads and collects the returned bytes.
   Assumes clk is the engine's system clock. */
`timescale 1ns/1ps
module sso_host (
    // System clock.
    input wire logic clk,
    // Serial pins.
    output logic cs_n,
    output logic sclk,
    output logic sin,
    input wire logic sout,
    input wire logic sout_oe_n
);
    logic [7:0] rx[$];
    logic oe_seen;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sin = 1'b0;
    end
    task automatic half();
        repeat (6) @(posedge clk);
    endtask : half
    // Sends code, address and dummy byte, then reads n bytes.
    task automatic frame(input logic [7:0] op, input logic [23:0] addr,
                         input int n);
        logic [39:0] hdr;
        logic [7:0] b;
        hdr = {op, addr, 8'h00};
        rx.delete();
        oe_seen = 1'b0;
        cs_n <= 1'b0;
        half();
        for (int i = 39; i >= 0; i--) begin
            sclk <= 1'b0;
            sin <= hdr[i];
            half();
            sclk <= 1'b1;
            half();
        end
        for (int k = 0; k < 8 * n; k++) begin
            sclk <= 1'b0;
            sin <= ~sin;
            half();
            b = {b[6:0], sout};
            oe_seen |= ~sout_oe_n;
            sclk <= 1'b1;
            half();
            if (k % 8 == 7) begin
                rx.push_back(b);
            end
        end
        sclk <= 1'b0;
        half();
        cs_n <= 1'b1;
        sin <= ~sin;
        half();
    endtask : frame
endmodule : sso_host

// ===== testbench/testbench.sv
/* Self-checking bench for the read engine.
   Assumes the host model and the checker are compiled with it. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module testbench;
    import sso_pkg::*;
    logic clk, rst, cs_n, sclk, sin, sout, oe_n, busy, fvalid, fready;
    sso_addr_s faddr;
    logic [7:0] fdata;
    int failures = 0;
    int compares = 0;
    function automatic logic [7:0] exp_b(logic [7:0] s, logic [7:0] o);
        return s ^ {o[6:0], o[7]};
    endfunction : exp_b
    assign fdata = exp_b(faddr.select, faddr.offset);
    sso_read dut (.clk(clk), .rst(rst), .cs_n_pin(cs_n), .sclk_pin(sclk),
        .serial_in_pin(sin), .serial_out(sout), .serial_out_oe_n(oe_n),
        .busy(busy), .fetch_addr(faddr), .fetch_ready(fready),
        .fetch_valid(fvalid), .fetch_data(fdata));
    sso_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sin(sin),
        .sout(sout), .sout_oe_n(oe_n));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        fvalid <= rst ? 1'b0 : ~fvalid;
    end
    task automatic finish_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    task automatic t_secreg();
        logic [7:0] sel[3] = '{8'h11, 8'h21, 8'h31};
        for (int r = 0; r < 3; r++) begin
            host.frame(SSO_OP_SECREG_RD, {8'h00, sel[r], 8'hFE}, 3);
            `CHK("sec drive", 1'b1, host.oe_seen)
            for (int k = 0; k < 3; k++)
                `CHK("sec byte", exp_b(sel[r], 8'(254 + k)), host.rx[k])
        end
    endtask : t_secreg
    task automatic t_uid();
        logic [7:0] e;
        host.frame(SSO_OP_UID_RD, 24'h00_0000, 17);
        for (int k = 0; k < 17; k++) begin
            e = SSO_UID_DEFAULT[127 - 8 * (k % 16) -: 8];
            `CHK("uid byte", e, host.rx[k])
        end
    endtask : t_uid
    task automatic t_refuse();
        busy <= 1'b1;
        host.frame(SSO_OP_SECREG_RD, 24'h00_1100, 1);
        `CHK("busy drive", 1'b0, host.oe_seen)
        busy <= 1'b0;
        host.frame(8'h03, 24'h00_2100, 1);
        `CHK("bad code drive", 1'b0, host.oe_seen)
    endtask : t_refuse
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        finish_test();
    end
    initial begin
        rst = 1'b1;
        busy = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_secreg();
        t_uid();
        t_refuse();
        finish_test();
    end
endmodule : testbench
